// file: design/sss_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sss_consts.svh"
// Operation
// - four weighted bits form selection code
// - bit follows its trigger level
// - 0 none, 1..8 segment, above invalid
// - selection used only without running sequence
// - each bit has configurable source, default none
// - valid nonzero code switches active setpoint
module sss_top
    import sss_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // trigger sources, index 0 is not connected
    input wire logic [`SSS_NUM_SRC-1:0] trig_in,
    // source assignments
    input wire logic [`SSS_SRC_W-1:0] segment_select_weight1_source,
    input wire logic [`SSS_SRC_W-1:0] segment_select_weight2_source,
    input wire logic [`SSS_SRC_W-1:0] segment_select_weight4_source,
    input wire logic [`SSS_SRC_W-1:0] segment_select_weight8_source,
    // operating state
    input wire logic sequence_active,
    // default setpoints when no segment is chosen
    input wire logic [`SSS_SP_W-1:0] base_frequency_setpoint,
    input wire logic [`SSS_SP_W-1:0] base_pid_setpoint,
    input wire logic [`SSS_SP_W-1:0] base_torque_setpoint,
    // segment setpoints, segment n at slice n-1
    input wire logic [`SSS_NUM_SEG*`SSS_SP_W-1:0] seg_frequency_setpoints,
    input wire logic [`SSS_NUM_SEG*`SSS_SP_W-1:0] seg_pid_setpoints,
    input wire logic [`SSS_NUM_SEG*`SSS_SP_W-1:0] seg_torque_setpoints,
    // results
    output logic [`SSS_SEL_W-1:0] sel_code,
    output logic [`SSS_SEG_W-1:0] active_segment,
    output logic segment_active,
    output logic sel_invalid,
    output logic [`SSS_SP_W-1:0] frequency_setpoint,
    output logic [`SSS_SP_W-1:0] pid_setpoint,
    output logic [`SSS_SP_W-1:0] torque_setpoint
);
    // the mapper sees only synchronised triggers, so a glitch on a pin
    // cannot reach the code in the cycle it happens; the interface keeps
    // the trigger fan-in and the code together between the two modules
    sss_trig_if tif();

    logic [`SSS_NUM_SRC-1:0] trig_meta_reg, trig_meta_next;
    logic [`SSS_NUM_SRC-1:0] trig_sync_reg, trig_sync_next;
    logic seq_meta_reg, seq_meta_next;
    logic seq_sync_reg, seq_sync_next;
    logic [`SSS_SEL_W-1:0] code_reg, code_next;
    logic [`SSS_SEG_W-1:0] seg_reg, seg_next;
    logic act_reg, act_next;
    logic inv_reg, inv_next;
    sss_sp_t freq_reg, freq_next;
    sss_sp_t pid_reg, pid_next;
    sss_sp_t torq_reg, torq_next;
    sss_sel_e kind;

    sss_trig_map u_map (
        .tif(tif.mapper),
        .src_w1(segment_select_weight1_source),
        .src_w2(segment_select_weight2_source),
        .src_w4(segment_select_weight4_source),
        .src_w8(segment_select_weight8_source)
    );

    // pins are asynchronous to clk, so two stages first
    always_comb begin
        trig_meta_next = trig_in;
        trig_sync_next = trig_meta_reg;
        seq_meta_next = sequence_active;
        seq_sync_next = seq_meta_reg;
    end

    assign tif.trig_sync = trig_sync_reg;

    // classify the code; codes above the segment count are refused,
    // never clipped onto the last segment
    function automatic sss_sel_e classify(input logic [`SSS_SEL_W-1:0] c);
        if (c == `SSS_CODE_NONE)
            return SSS_SEL_NONE;
        if (c <= `SSS_CODE_MAX)
            return SSS_SEL_SEG;
        return SSS_SEL_INVALID;
    endfunction

    // segment n lives at slice n-1; callers pass codes 1..8 only, as
    // code 0 would wrap round to the top slice
    function automatic sss_sp_t slice(
        input logic [`SSS_NUM_SEG*`SSS_SP_W-1:0] v,
        input logic [`SSS_SEL_W-1:0] c);
        logic [`SSS_SEL_W-1:0] idx;
        idx = c - `SSS_SEL_W'(1);
        return v[idx[`SSS_IDX_W-1:0]*`SSS_SP_W +: `SSS_SP_W];
    endfunction

    // latency: triggers reach the outputs three edges after a pin
    // moves, setpoints and sources one edge after they change; the
    // sequencer input runs through the same two stages as the triggers,
    // so a sequence start and a code change are seen on the same edge
    // limitation: a trigger pulse shorter than one clock may be missed;
    // the triggers are levels, so that is acceptable

    // two-stage synchronisers; only the second stage feeds logic
    // the config ports are static and skip this
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta_reg <= '0;
            trig_sync_reg <= '0;
            seq_meta_reg <= 1'b0;
            seq_sync_reg <= 1'b0;
        end else begin
            trig_meta_reg <= trig_meta_next;
            trig_sync_reg <= trig_sync_next;
            seq_meta_reg <= seq_meta_next;
            seq_sync_reg <= seq_sync_next;
        end
    end

    // raw code and its validity; invalid is flagged under a sequence too
    // kind is pure decode, so it is not a register
    always_comb begin
        kind = classify(tif.sel_code);
        code_next = tif.sel_code;
        // code 9 and above is refused, not clipped
        inv_next = (kind == SSS_SEL_INVALID);
    end

    // code group registers; the code is shown raw to help debug wiring
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_reg <= `SSS_CODE_NONE;
            inv_reg <= 1'b0;
        end else begin
            code_reg <= code_next;
            inv_reg <= inv_next;
        end
    end

    // segment choice; the sequencer owns the setpoint while it runs
    always_comb begin
        act_next = 1'b0;
        seg_next = `SSS_SEG_NONE;
        case (kind)
            SSS_SEL_SEG: begin
                // a sequence in progress keeps the selection from acting
                if (!seq_sync_reg) begin
                    act_next = 1'b1;
                    seg_next = tif.sel_code;
                end
            end
            SSS_SEL_NONE: begin
                // no segment: the base setpoints keep the drive running
                act_next = 1'b0;
            end
            SSS_SEL_INVALID: begin
                // a bad code must never pick a segment by accident
                act_next = 1'b0;
            end
            default: begin
                // kind only takes the three values above
                act_next = 1'b0;
            end
        endcase
    end

    // selection group registers; reset leaves no segment chosen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seg_reg <= `SSS_SEG_NONE;
            act_reg <= 1'b0;
        end else begin
            seg_reg <= seg_next;
            act_reg <= act_next;
        end
    end

    // setpoint mux; base values stand whenever no segment is chosen
    // the slices come straight from the ports, which are static
    // configuration, so they skip the synchronisers
    always_comb begin
        freq_next = base_frequency_setpoint;
        pid_next = base_pid_setpoint;
        torq_next = base_torque_setpoint;
        // same condition as the segment flag, so the outputs agree
        if (act_next) begin
            freq_next = slice(seg_frequency_setpoints, tif.sel_code);
            pid_next = slice(seg_pid_setpoints, tif.sel_code);
            torq_next = slice(seg_torque_setpoints, tif.sel_code);
        end
    end

    // setpoint group registers; the whole word moves on one edge, so a
    // consumer never sees a half-switched setpoint
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // zero until the first decode after reset
            freq_reg <= `SSS_SP_ZERO;
            pid_reg <= `SSS_SP_ZERO;
            torq_reg <= `SSS_SP_ZERO;
        end else begin
            freq_reg <= freq_next;
            pid_reg <= pid_next;
            torq_reg <= torq_next;
        end
    end

    // every output comes straight from a register
    assign sel_code = code_reg;
    assign active_segment = seg_reg;
    assign segment_active = act_reg;
    assign sel_invalid = inv_reg;
    assign frequency_setpoint = freq_reg;
    assign pid_setpoint = pid_reg;
    assign torque_setpoint = torq_reg;
endmodule
`default_nettype wire

// file: design/sss_consts.svh
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH
`define SSS_SEL_W 4
`define SSS_SRC_W 8
`define SSS_NUM_SRC 16
`define SSS_SRC_NC 8'h00
`define SSS_SP_W 32
`define SSS_NUM_SEG 8
`define SSS_CODE_NONE 4'h0
`define SSS_CODE_MAX 4'h8
`define SSS_BIT0 0
`define SSS_BIT3 3
`define SSS_SEG_W 4
`define SSS_IDX_W 3
`define SSS_SEG_NONE 4'h0
`define SSS_SP_ZERO 32'h00000000
`endif

// file: design/sss_pkg.sv
`include "sss_consts.svh"
package sss_pkg;
    typedef logic [`SSS_SP_W-1:0] sss_sp_t;
    typedef enum logic [1:0] {
        SSS_SEL_NONE,
        SSS_SEL_SEG,
        SSS_SEL_INVALID
    } sss_sel_e;
endpackage

// file: design/sss_trig_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "sss_consts.svh"
interface sss_trig_if;
    logic [`SSS_NUM_SRC-1:0] trig_sync;
    logic [`SSS_SEL_W-1:0] sel_code;
    modport mapper (input trig_sync, output sel_code);
    modport user (output trig_sync, input sel_code);
endinterface
`default_nettype wire

// file: design/sss_trig_map.sv
`timescale 1ns/10ps
`default_nettype none
`include "sss_consts.svh"
module sss_trig_map
    import sss_pkg::*;
(
    // trigger fan-in and code out
    sss_trig_if.mapper tif,
    // source choice per selection bit
    input wire logic [`SSS_SRC_W-1:0] src_w1,
    input wire logic [`SSS_SRC_W-1:0] src_w2,
    input wire logic [`SSS_SRC_W-1:0] src_w4,
    input wire logic [`SSS_SRC_W-1:0] src_w8
);
    // unconnected or out-of-range source reads FALSE
    function automatic logic pick(input logic [`SSS_SRC_W-1:0] src,
                                  input logic [`SSS_NUM_SRC-1:0] trg);
        if (src == `SSS_SRC_NC || src >= `SSS_SRC_W'(`SSS_NUM_SRC))
            return 1'b0;
        return trg[src[`SSS_SEG_W-1:0]];
    endfunction

    // weights 1,2,4,8 go to bits 0..3
    always_comb begin
        tif.sel_code = {pick(src_w8, tif.trig_sync),
                        pick(src_w4, tif.trig_sync),
                        pick(src_w2, tif.trig_sync),
                        pick(src_w1, tif.trig_sync)};
    end
endmodule
`default_nettype wire

// file: test/sss_trig_src.sv
`timescale 1ns/10ps
`default_nettype none
module sss_trig_src (
    // clock and wanted trigger states
    input wire logic clk,
    input wire logic [15:0] want,
    // trigger lines
    output logic [15:0] trig_in
);
    // source 0 is unwired, so it carries noise that must be ignored
    always @(posedge clk) begin
        trig_in <= {want[15:1], 1'($urandom)};
    end
endmodule
`default_nettype wire

// file: test/sss_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sss_top_asserts (
    // watched ports
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] trig_in,
    input wire logic [7:0] segment_select_weight1_source,
    input wire logic sequence_active,
    input wire logic [31:0] base_frequency_setpoint,
    input wire logic [255:0] seg_frequency_setpoints,
    input wire logic [3:0] sel_code,
    input wire logic [3:0] active_segment,
    input wire logic segment_active,
    input wire logic sel_invalid,
    input wire logic [31:0] frequency_setpoint
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic [7:0] s1 = segment_select_weight1_source;
    // three samples cover the sync chain, so the check is conservative
    sequence seq_held; sequence_active [*3]; endsequence
    sequence src1_none; (s1 == 8'h00) [*2]; endsequence
    a_code_none: assert property (sel_code == 4'h0 |->
        !segment_active && !sel_invalid) else $error("code 0 chose");
    a_invalid_flag: assert property (sel_invalid ==
        (sel_code > 4'h8)) else $error("invalid flag wrong");
    a_seg_number: assert property (segment_active |->
        active_segment == sel_code && sel_code inside {[1:8]})
        else $error("segment number wrong");
    a_idle_base: assert property ($past(rst_n) && !segment_active |->
        active_segment == 4'h0 &&
        frequency_setpoint == $past(base_frequency_setpoint))
        else $error("idle output wrong");
    a_seq_blocks: assert property (seq_held |=>
        !segment_active) else $error("segment during sequence");
    a_nc_low: assert property (src1_none |-> !sel_code[0])
        else $error("unconnected bit set");
    a_bit_follows: assert property ((s1 != 8'h00 && s1 < 8'h10 &&
        $stable(s1) && $stable(trig_in[s1[3:0]])) [*4] |->
        sel_code[0] == trig_in[s1[3:0]]) else $error("bit not tracking");
    a_seg_freq: assert property (segment_active |->
        frequency_setpoint == 32'($past(seg_frequency_setpoints) >>
        (32 * (active_segment - 4'h1)))) else $error("segment setpoint");
endmodule
bind sss_top sss_top_asserts chk (.clk, .rst_n, .trig_in,
    .segment_select_weight1_source, .sequence_active,
    .base_frequency_setpoint, .seg_frequency_setpoints, .sel_code,
    .active_segment, .segment_active, .sel_invalid, .frequency_setpoint);
`default_nettype wire

// file: test/tb_segment_setpoint_selector.sv
`timescale 1ns/10ps
`default_nettype none
module tb_segment_setpoint_selector;
    import sss_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic seq = 1'b0;
    logic [15:0] want = 16'h0000;
    logic [15:0] trig;
    logic [7:0] src [4] = '{default: 8'h00};
    sss_sp_t base = 32'h00000000;
    logic [255:0] segf = 256'h0;
    logic [3:0] code, seg;
    logic act, inv;
    sss_sp_t f, p, t;
    logic [15:0] w;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // out-of-range and zero sources both leave the bit low
    function automatic logic [3:0] exp_code();
        logic [3:0] r;
        for (int i = 0; i < 4; i++) r[i] = src[i] inside {[1:15]} && want[src[i]];
        return r;
    endfunction
    task automatic check();
        logic [3:0] e;
        logic s;
        e = exp_code();
        s = e inside {[1:8]} && !seq;
        cmp(code, e);
        cmp(act, s);
        cmp(seg, s ? e : 4'h0);
        cmp(inv, e > 4'h8);
        cmp(f, s ? segf[(e - 1) * 32 +: 32] : base);
        cmp(p, s ? ~segf[(e - 1) * 32 +: 32] : ~base);
        cmp(t, s ? ~segf[(e - 1) * 32 +: 32] : ~base);
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            final_report();
        end
    end
    sss_trig_src src_model (.clk(clk), .want(want), .trig_in(trig));
    sss_top dut (.clk(clk), .rst_n(rst_n), .trig_in(trig),
        .segment_select_weight1_source(src[0]),
        .segment_select_weight2_source(src[1]),
        .segment_select_weight4_source(src[2]),
        .segment_select_weight8_source(src[3]), .sequence_active(seq),
        .base_frequency_setpoint(base), .base_pid_setpoint(~base),
        .base_torque_setpoint(~base), .seg_frequency_setpoints(segf),
        .seg_pid_setpoints(~segf), .seg_torque_setpoints(~segf),
        .sel_code(code), .active_segment(seg), .segment_active(act),
        .sel_invalid(inv), .frequency_setpoint(f), .pid_setpoint(p),
        .torque_setpoint(t));
    initial begin
        void'($urandom(32'hbb5a5736));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) segf[i * 32 +: 32] <= $urandom;
        want <= 16'($urandom);
        repeat (5) @(posedge clk);
        #1 check();
        @(posedge clk);
        src <= '{8'h01, 8'h02, 8'h03, 8'h04};
        for (int k = 0; k < 60; k++) begin
            @(posedge clk);
            w = 16'($urandom);
            if (k < 16) w[4:1] = 4'(k);
            want <= w;
            base <= $urandom;
            // sequencer runs now and then; selection must not act
            seq <= (k % 7 == 6);
            src[3] <= (k % 5 == 4) ? 8'h20 : 8'h04;
            repeat (5) @(posedge clk);
            #1 check();
        end
        final_report();
    end
endmodule
`default_nettype wire
